// file: design/clock_tree_consts.svh
`ifndef CLOCK_TREE_CONSTS_SVH
`define CLOCK_TREE_CONSTS_SVH

// Sizes of the clock tree
`define PERIPH_COUNT      17
`define OUT_CLOCK_COUNT   2
`define FREQ_WIDTH        16
`define CNT_WIDTH         11

// Timing counts, in slow or bus clock ticks
`define OSC_UNIT_CYCLES   11'h008
`define FREQ_WINDOW_LAST  4'hf
`define BUS_SETTLE_TICKS  2'h2

// Reset values
`define PLL_SETTLE_RESET  6'h3f

`endif

// file: design/clock_tree_pkg.sv
package clock_tree_pkg;

`include "clock_tree_consts.svh"

    // Clock source codes, shared by bus clock and output clocks
    typedef enum logic [1:0] {
        SRC_SLOW  = 2'b00,
        SRC_MAIN  = 2'b01,
        SRC_PLL_A = 2'b10,
        SRC_PLL_B = 2'b11
    } clk_src_e;

    typedef enum logic [1:0] {
        FM_IDLE  = 2'b00,
        FM_COUNT = 2'b01,
        FM_DONE  = 2'b10
    } freq_fsm_e;

    // Loop configuration; source_sel and usb_clock_ratio apply to one loop each
    typedef struct packed {
        logic        source_sel;
        logic [1:0]  usb_clock_ratio;
        logic [10:0] multiplier;
        logic [1:0]  range_sel;
        logic [5:0]  settle_cycles;
        logic [7:0]  input_divider;
    } pll_cfg_s;

    typedef struct packed {
        logic [1:0] core_to_bus_ratio;
        logic [2:0] power_of_two_divide;
        clk_src_e   clock_source_select;
    } bus_cfg_s;

    typedef struct packed {
        logic [2:0] power_of_two_divide;
        clk_src_e   clock_source_select;
    } out_cfg_s;

    typedef struct packed {
        logic [1:0] output_clock_ready;
        logic       main_bus_clock_ready;
        logic       pll_b_locked_flag;
        logic       pll_a_locked_flag;
        logic       freq_measure_done;
        logic       osc_stable_flag;
    } clk_status_s;

    typedef struct packed {
        logic [5:0] cnt;
        logic       tick;
    } div_state_s;

    typedef struct packed {
        logic [2:0]                 slow_sync;
        logic [2:0]                 main_sync;
        logic                       osc_en;
        logic [`CNT_WIDTH-1:0]      osc_cnt;
        freq_fsm_e                  fm;
        logic [3:0]                 freq_slow;
        logic [`FREQ_WIDTH-1:0]     freq_cnt;
        pll_cfg_s                   pll_a;
        pll_cfg_s                   pll_b;
        logic [5:0]                 lock_a_cnt;
        logic [5:0]                 lock_b_cnt;
        logic [1:0]                 pump;
        bus_cfg_s                   bus;
        logic [1:0]                 bus_settle;
        out_cfg_s [1:0]             out_cfg;
        logic [1:0]                 out_on;
        logic [1:0]                 out_pin;
        logic [`PERIPH_COUNT-1:0]   periph_state;
        logic [`PERIPH_COUNT-1:0]   periph_en;
        logic                       cpu_en;
        logic                       bus_en;
        logic                       usb_en;
        logic                       irq;
        clk_status_s                status;
    } ctrl_state_s;

    // True on the last tick of each group of 2**ratio ticks, at most 64 ticks (ratio 7 acts as 6)
    function automatic logic pow2_hit(input logic [5:0] cnt, input logic [2:0] ratio);
        logic [6:0] span;
        span = (7'h01 << ratio) - 7'h01;
        return (cnt & span[5:0]) == span[5:0];
    endfunction : pow2_hit

    // Down counter step: {done, next}; done on the tick that ends the wait
    function automatic logic [`CNT_WIDTH:0] countdown(input logic [`CNT_WIDTH-1:0] cnt);
        logic done;
        done = (cnt <= `CNT_WIDTH'(1));
        return {done, done ? {`CNT_WIDTH{1'b0}} : cnt - `CNT_WIDTH'(1)};
    endfunction : countdown

    function automatic logic pick_source(input clk_src_e sel, input logic slow,
                                         input logic main, input logic a, input logic b);
        case (sel)
            SRC_SLOW:  return slow;
            SRC_MAIN:  return main;
            SRC_PLL_A: return a;
            default:   return b;
        endcase
    endfunction : pick_source

endpackage : clock_tree_pkg

// file: design/clk_pow2_div.sv
`timescale 1ns/1ps
module clk_pow2_div
    import clock_tree_pkg::*;
(
    // Clock and reset
    input  wire logic       sys_clk_i,
    input  wire logic       srst_i,
    // Tick in, ratio as power of two
    input  wire logic       clear_i,
    input  wire logic       tick_i,
    input  wire logic [2:0] ratio_i,
    // Divided tick
    output logic            tick_o
);

    div_state_s st;
    div_state_s next_st;

    // Count incoming ticks; clear restarts the group
    always_comb begin
        next_st      = st;
        next_st.tick = 1'b0;
        if (clear_i) begin
            next_st.cnt = '0;
        end else if (tick_i) begin
            next_st.tick = pow2_hit(st.cnt, ratio_i);
            next_st.cnt  = st.cnt + 6'h01;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign tick_o = st.tick;

    div_unity_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        (tick_i && !clear_i && ratio_i == 3'h0) |=> tick_o)
        else $error("divide by one dropped a tick");

endmodule : clk_pow2_div

// file: design/clock_tree_setup_control.sv
`timescale 1ns/1ps
`include "clock_tree_consts.svh"
module clock_tree_setup_control
    import clock_tree_pkg::*;
(
    // Clock and reset
    input  wire logic                     sys_clk_i,
    input  wire logic                     srst_i,
    // Clock sources: pins asynchronous, loop ticks local enables
    input  wire logic                     low_speed_clock_i,
    input  wire logic                     main_clock_i,
    input  wire logic                     first_loop_clock_tick_i,
    input  wire logic                     second_loop_clock_tick_i,
    // Oscillator control
    input  wire logic                     osc_ctrl_wr_i,
    input  wire logic                     osc_enable_i,
    input  wire logic [7:0]               osc_startup_count_i,
    // Loop configuration
    input  wire logic                     pump_current_wr_i,
    input  wire logic [1:0]               pump_current_sel_i,
    input  wire logic                     loop_a_wr_i,
    input  wire pll_cfg_s                 loop_a_cfg_i,
    input  wire logic                     loop_b_wr_i,
    input  wire pll_cfg_s                 loop_b_cfg_i,
    // Bus clock configuration
    input  wire logic                     bus_clock_wr_i,
    input  wire bus_cfg_s                 bus_clock_cfg_i,
    // Output clock configuration and masks
    input  wire logic [1:0]               output_clock_wr_i,
    input  wire out_cfg_s [1:0]           output_clock_cfg_i,
    input  wire logic [1:0]               output_clock_on_i,
    input  wire logic [1:0]               output_clock_off_i,
    // Peripheral clock masks
    input  wire logic [`PERIPH_COUNT-1:0] periph_clock_on_i,
    input  wire logic [`PERIPH_COUNT-1:0] periph_clock_off_i,
    // Interrupt enables, one per status flag
    input  wire clk_status_s              irq_enable_i,
    // Status
    output clk_status_s                   status_o,
    output logic [`FREQ_WIDTH-1:0]        measured_freq_count_o,
    output logic [1:0]                    output_clock_state_o,
    output logic [`PERIPH_COUNT-1:0]      periph_clock_state_o,
    output logic                          irq_o,
    // Loop settings to the analog loops
    output pll_cfg_s                      loop_a_cfg_o,
    output pll_cfg_s                      loop_b_cfg_o,
    output logic [1:0]                    pump_current_sel_o,
    // Generated clock enables and pins
    output logic                          cpu_clk_en_o,
    output logic                          bus_clk_en_o,
    output logic                          usb_clk_en_o,
    output logic [`PERIPH_COUNT-1:0]      periph_clk_en_o,
    output logic [1:0]                    output_clock_pin_o
);

    ctrl_state_s st;
    ctrl_state_s next_st;

    logic     slow_tick;
    logic     main_tick;
    logic     loop_a_run;
    logic     loop_b_run;
    logic     loop_a_tick;
    logic     loop_b_tick;
    logic     src_tick;
    logic     cpu_tick;
    logic     bus_tick;
    logic     usb_tick;
    logic     bus_change;
    clk_src_e eff_src;
    logic [1:0] out_src_tick;
    logic [1:0] out_tick;

    // Edges of synchronised pins; stage 0 feeds only stage 1
    assign slow_tick  = st.slow_sync[1] & ~st.slow_sync[2];
    assign main_tick  = st.main_sync[1] & ~st.main_sync[2];

    // A zero divider or multiplier holds the loop off
    assign loop_a_run  = (st.pll_a.multiplier != '0) && (st.pll_a.input_divider != '0);
    assign loop_b_run  = (st.pll_b.multiplier != '0) && (st.pll_b.input_divider != '0);
    assign loop_a_tick = first_loop_clock_tick_i & loop_a_run;
    assign loop_b_tick = second_loop_clock_tick_i & loop_b_run;

    assign bus_change = bus_clock_wr_i &&
        ((bus_clock_cfg_i.clock_source_select != st.bus.clock_source_select) ||
         (bus_clock_cfg_i.power_of_two_divide != st.bus.power_of_two_divide));

    // Fallback while the selected loop is unlocked
    always_comb begin
        eff_src = st.bus.clock_source_select;
        if (eff_src == SRC_PLL_A && !st.status.pll_a_locked_flag) begin
            eff_src = SRC_SLOW;
        end else if (eff_src == SRC_PLL_B && !st.status.pll_b_locked_flag) begin
            eff_src = SRC_MAIN;
        end
    end

    assign src_tick = pick_source(eff_src, slow_tick, main_tick, loop_a_tick, loop_b_tick);

    // Bus clock prescaler, then processor-to-bus ratio
    clk_pow2_div u_bus_power_of_two_divide (
        .sys_clk_i (sys_clk_i),
        .srst_i    (srst_i),
        .clear_i   (bus_clock_wr_i),
        .tick_i    (src_tick),
        .ratio_i   (st.bus.power_of_two_divide),
        .tick_o    (cpu_tick)
    );

    clk_pow2_div u_bus_ratio (
        .sys_clk_i (sys_clk_i),
        .srst_i    (srst_i),
        .clear_i   (bus_clock_wr_i),
        .tick_i    (cpu_tick),
        .ratio_i   ({1'b0, st.bus.core_to_bus_ratio}),
        .tick_o    (bus_tick)
    );

    // USB divider runs only from a locked loop B
    clk_pow2_div u_usb_div (
        .sys_clk_i (sys_clk_i),
        .srst_i    (srst_i),
        .clear_i   (!st.status.pll_b_locked_flag),
        .tick_i    (loop_b_tick),
        .ratio_i   ({1'b0, st.pll_b.usb_clock_ratio}),
        .tick_o    (usb_tick)
    );

    // Output clock dividers, held cleared while the output is off
    for (genvar g = 0; g < `OUT_CLOCK_COUNT; g++) begin : g_out
        assign out_src_tick[g] = pick_source(st.out_cfg[g].clock_source_select, slow_tick,
                                             main_tick, loop_a_tick, loop_b_tick);
        clk_pow2_div u_out_div (
            .sys_clk_i (sys_clk_i),
            .srst_i    (srst_i),
            .clear_i   (!st.out_on[g] || output_clock_wr_i[g]),
            .tick_i    (out_src_tick[g]),
            .ratio_i   (st.out_cfg[g].power_of_two_divide),
            .tick_o    (out_tick[g])
        );
    end

    // Whole control state, next value
    always_comb begin
        logic [`CNT_WIDTH:0] step;
        logic                loop_ok;
        step    = '0;
        loop_ok = 1'b0;
        next_st = st;
        next_st.slow_sync = {st.slow_sync[1:0], low_speed_clock_i};
        next_st.main_sync = {st.main_sync[1:0], main_clock_i};

        // Oscillator start-up wait; a new write restarts the measurement too
        if (osc_ctrl_wr_i) begin
            next_st.osc_en  = osc_enable_i;
            next_st.osc_cnt = `CNT_WIDTH'(osc_startup_count_i) * `OSC_UNIT_CYCLES;
            next_st.status.osc_stable_flag   = 1'b0;
            next_st.status.freq_measure_done = 1'b0;
            next_st.fm = FM_IDLE;
        end else if (st.osc_en && !st.status.osc_stable_flag && slow_tick) begin
            step = countdown(st.osc_cnt);
            next_st.osc_cnt = step[`CNT_WIDTH-1:0];
            next_st.status.osc_stable_flag = step[`CNT_WIDTH];
        end

        // Main clock measurement over a window of slow ticks
        case (st.fm)
            FM_IDLE: begin
                if (st.status.osc_stable_flag && slow_tick && !osc_ctrl_wr_i) begin
                    next_st.fm        = FM_COUNT;
                    next_st.freq_slow = '0;
                    next_st.freq_cnt  = '0;
                end
            end
            FM_COUNT: begin
                if (osc_ctrl_wr_i) begin
                    next_st.fm = FM_IDLE;
                end else begin
                    if (main_tick) begin
                        next_st.freq_cnt = st.freq_cnt + `FREQ_WIDTH'(1);
                    end
                    if (slow_tick) begin
                        next_st.freq_slow = st.freq_slow + 4'h1;
                        if (st.freq_slow == `FREQ_WINDOW_LAST) begin
                            next_st.fm = FM_DONE;
                            next_st.status.freq_measure_done = 1'b1;
                        end
                    end
                end
            end
            FM_DONE: begin
            end
            default: begin
                next_st.fm = FM_IDLE;
            end
        endcase

        if (pump_current_wr_i) begin
            next_st.pump = pump_current_sel_i;
        end

        // Loop A: any write drops lock and reloads the settle wait
        if (loop_a_wr_i) begin
            next_st.pll_a      = loop_a_cfg_i;
            next_st.lock_a_cnt = loop_a_cfg_i.settle_cycles;
            next_st.status.pll_a_locked_flag = 1'b0;
        end else if (!st.status.pll_a_locked_flag && loop_a_run && slow_tick) begin
            step = countdown(`CNT_WIDTH'(st.lock_a_cnt));
            next_st.lock_a_cnt = step[5:0];
            next_st.status.pll_a_locked_flag = step[`CNT_WIDTH];
        end

        // Loop B, same scheme
        if (loop_b_wr_i) begin
            next_st.pll_b      = loop_b_cfg_i;
            next_st.lock_b_cnt = loop_b_cfg_i.settle_cycles;
            next_st.status.pll_b_locked_flag = 1'b0;
        end else if (!st.status.pll_b_locked_flag && loop_b_run && slow_tick) begin
            step = countdown(`CNT_WIDTH'(st.lock_b_cnt));
            next_st.lock_b_cnt = step[5:0];
            next_st.status.pll_b_locked_flag = step[`CNT_WIDTH];
        end

        // Bus clock: a changed source or prescaler waits for new ticks
        if (bus_clock_wr_i) begin
            next_st.bus = bus_clock_cfg_i;
        end
        if (bus_change) begin
            next_st.bus_settle = `BUS_SETTLE_TICKS;
            next_st.status.main_bus_clock_ready = 1'b0;
        end else if (bus_tick && st.bus_settle != '0) begin
            step = countdown(`CNT_WIDTH'(st.bus_settle));
            next_st.bus_settle = step[1:0];
        end
        loop_ok = !((next_st.bus.clock_source_select == SRC_PLL_A &&
                     !next_st.status.pll_a_locked_flag) ||
                    (next_st.bus.clock_source_select == SRC_PLL_B &&
                     !next_st.status.pll_b_locked_flag));
        if (!loop_ok) begin
            next_st.status.main_bus_clock_ready = 1'b0;
        end else if (!bus_change && next_st.bus_settle == '0) begin
            next_st.status.main_bus_clock_ready = 1'b1;
        end

        // Output clocks; disable wins when both mask bits are set
        for (int i = 0; i < `OUT_CLOCK_COUNT; i++) begin
            if (output_clock_wr_i[i]) begin
                next_st.out_cfg[i] = output_clock_cfg_i[i];
            end
            if (output_clock_on_i[i]) begin
                next_st.out_on[i] = 1'b1;
            end
            if (output_clock_off_i[i]) begin
                next_st.out_on[i] = 1'b0;
            end
            if (!next_st.out_on[i]) begin
                next_st.out_pin[i] = 1'b0;
                next_st.status.output_clock_ready[i] = 1'b0;
            end else if (out_tick[i]) begin
                next_st.out_pin[i] = ~st.out_pin[i];
                next_st.status.output_clock_ready[i] = 1'b1;
            end
        end

        // Peripheral gates act on whole bus ticks only, so no runt pulse
        next_st.periph_state = (st.periph_state | periph_clock_on_i) & ~periph_clock_off_i;
        next_st.periph_en    = next_st.periph_state & {`PERIPH_COUNT{bus_tick}};
        next_st.cpu_en       = cpu_tick;
        next_st.bus_en       = bus_tick;
        next_st.usb_en       = usb_tick;
        next_st.irq          = |(next_st.status & irq_enable_i);
    end

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            st <= '0;
            st.pll_a.settle_cycles <= `PLL_SETTLE_RESET;
            st.pll_b.settle_cycles <= `PLL_SETTLE_RESET;
            st.status.main_bus_clock_ready <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    // Outputs straight from state
    assign status_o              = st.status;
    assign measured_freq_count_o = st.freq_cnt;
    assign output_clock_state_o  = st.out_on;
    assign periph_clock_state_o  = st.periph_state;
    assign irq_o                 = st.irq;
    assign loop_a_cfg_o          = st.pll_a;
    assign loop_b_cfg_o          = st.pll_b;
    assign pump_current_sel_o    = st.pump;
    assign cpu_clk_en_o          = st.cpu_en;
    assign bus_clk_en_o          = st.bus_en;
    assign usb_clk_en_o          = st.usb_en;
    assign periph_clk_en_o       = st.periph_en;
    assign output_clock_pin_o    = st.out_pin;

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (srst_i);

    sequence loop_a_written;
        loop_a_wr_i;
    endsequence
    sequence loop_a_unlocked;
        !st.status.pll_a_locked_flag;
    endsequence

    osc_wait_a: assert property ($rose(st.status.osc_stable_flag) |->
        $past(slow_tick) && $past(st.osc_cnt) <= `CNT_WIDTH'(1))
        else $error("oscillator flagged stable before its count ran out");
    freq_window_a: assert property ($rose(st.status.freq_measure_done) |->
        $past(slow_tick) && $past(st.freq_slow) == `FREQ_WINDOW_LAST)
        else $error("measurement window not sixteen slow ticks");
    loop_off_a: assert property (st.status.pll_a_locked_flag |->
        st.pll_a.multiplier != '0 && st.pll_a.input_divider != '0)
        else $error("loop A locked while switched off");
    lock_wait_a: assert property ($rose(st.status.pll_b_locked_flag) |->
        $past(slow_tick) && $past(st.lock_b_cnt) <= 6'h01)
        else $error("loop B locked before settle count ran out");
    lock_a_drop_a: assert property (loop_a_written |=> loop_a_unlocked)
        else $error("loop A lock kept across a write");
    lock_b_drop_a: assert property (loop_b_wr_i |=> !st.status.pll_b_locked_flag)
        else $error("loop B lock kept across a write");
    bus_drop_a: assert property (bus_change |=> !st.status.main_bus_clock_ready)
        else $error("bus ready kept across a source change");
    bus_loop_a: assert property (st.status.main_bus_clock_ready &&
        st.bus.clock_source_select == SRC_PLL_A |-> st.status.pll_a_locked_flag)
        else $error("bus ready on an unlocked loop");
    fallback_a: assert property (st.bus.clock_source_select == SRC_PLL_B &&
        !st.status.pll_b_locked_flag |-> eff_src == SRC_MAIN)
        else $error("no fallback to main clock");
    periph_off_a: assert property (|periph_clock_off_i |=>
        ((st.periph_state | st.periph_en) & $past(periph_clock_off_i)) == '0)
        else $error("peripheral clock ran after disable");
    periph_gate_a: assert property (st.periph_en != '0 |-> st.bus_en)
        else $error("peripheral enable outside a bus tick");
    irq_out_a: assert property (|(st.status & irq_enable_i) && !$changed(irq_enable_i)
        |-> irq_o)
        else $error("enabled status flag did not raise interrupt");
    out_off_a: assert property (!st.out_on[0] |->
        !output_clock_pin_o[0] && !st.status.output_clock_ready[0])
        else $error("disabled output clock still active");

endmodule : clock_tree_setup_control

// file: tb/clock_sources_model.sv
`timescale 1ns/1ps
module clock_sources_model (
    // Bench clock
    input  wire logic  sys_clk_i,
    // Oscillator pins and loop ticks
    output logic       slow_o,
    output logic       main_o,
    output logic [1:0] tick_o
);
    logic [2:0] cnt = 3'h0;
    // Oscillators run free; slow period 8 cycles, main period 4
    always @(posedge sys_clk_i) cnt <= cnt + 3'h1;
    assign slow_o = cnt[2];
    assign main_o = cnt[1];
    assign tick_o = {&cnt[1:0], cnt[0]}; // One-cycle pulses, loop B slower
endmodule : clock_sources_model

// file: tb/testbench.sv
`timescale 1ns/1ps
module testbench;
    import clock_tree_pkg::*;
    logic sys_clk_i = 1'b0, srst_i = 1'b1, low_speed_clock_i, main_clock_i;
    logic osc_ctrl_wr_i = 1'b0, osc_enable_i = 1'b0, pump_current_wr_i = 1'b0;
    logic loop_a_wr_i = 1'b0, loop_b_wr_i = 1'b0, bus_clock_wr_i = 1'b0;
    logic [7:0] osc_startup_count_i = 8'h00;
    logic [1:0] ticks, pump_current_sel_i = 2'h0, output_clock_wr_i = 2'h0;
    logic [1:0] output_clock_on_i = 2'h0, output_clock_off_i = 2'h0, output_clock_state_o;
    pll_cfg_s loop_a_cfg_i = '0, loop_b_cfg_i = '0;
    bus_cfg_s bus_clock_cfg_i = '0;
    out_cfg_s [1:0] output_clock_cfg_i = '0;
    logic [16:0] periph_clock_on_i = 17'h0, periph_clock_off_i = 17'h0, periph_clock_state_o;
    clk_status_s irq_enable_i = '0, status_o;
    logic [1:0] pump_current_sel_o, output_clock_pin_o;
    logic [15:0] measured_freq_count_o;
    logic irq_o;
    pll_cfg_s loop_a_cfg_o;
    logic [20:0] notes[$];
    logic [20:0] n;
    logic [18:0] got;
    logic [18:0] r, k, s;
    int errors = 0, n_compared = 0, cyc = 0;
    clock_sources_model partner (.sys_clk_i, .slow_o(low_speed_clock_i),
        .main_o(main_clock_i), .tick_o(ticks));
    clock_tree_setup_control uut (.sys_clk_i, .srst_i, .low_speed_clock_i, .main_clock_i,
        .first_loop_clock_tick_i(ticks[0]), .second_loop_clock_tick_i(ticks[1]),
        .osc_ctrl_wr_i, .osc_enable_i, .osc_startup_count_i, .pump_current_wr_i,
        .pump_current_sel_i, .loop_a_wr_i, .loop_a_cfg_i, .loop_b_wr_i, .loop_b_cfg_i,
        .bus_clock_wr_i, .bus_clock_cfg_i, .output_clock_wr_i, .output_clock_cfg_i,
        .output_clock_on_i, .output_clock_off_i, .periph_clock_on_i, .periph_clock_off_i,
        .irq_enable_i, .status_o, .measured_freq_count_o, .output_clock_state_o,
        .periph_clock_state_o, .irq_o, .loop_a_cfg_o, .loop_b_cfg_o(),
        .pump_current_sel_o, .cpu_clk_en_o(), .bus_clk_en_o(), .usb_clk_en_o(),
        .periph_clk_en_o(), .output_clock_pin_o);
    task automatic step(input int cnt);
        repeat (cnt) @(posedge sys_clk_i);
    endtask : step
    task automatic check(input logic [18:0] seen, input logic [18:0] exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    // Status note; interrupt follows the enables in force at this edge, pins idle
    function automatic logic [20:0] st(input clk_status_s v);
        return {13'h0, |(v & irq_enable_i), v};
    endfunction : st
    task automatic print_verdict();
        $display("compared %0d, mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : print_verdict
    always #10 sys_clk_i = ~sys_clk_i;
    // Falling edge: outputs of the last rising edge have settled
    always @(negedge sys_clk_i) begin
        cyc++;
        if (notes.size() > 0) begin
            n = notes.pop_front();
            case (n[20:19])
                2'h0: got = {9'h0, output_clock_pin_o, irq_o, status_o};
                2'h1: got = {output_clock_state_o, periph_clock_state_o};
                2'h2: got = {1'b0, pump_current_sel_o, measured_freq_count_o};
                default: got = {loop_a_cfg_o.multiplier, loop_a_cfg_o.input_divider};
            endcase
            check(got, n[18:0]);
        end
        if (cyc == 2000) begin
            errors++;
            print_verdict();
        end
    end
    initial begin
        void'($urandom(58507));
        step(3);
        srst_i <= 1'b0;
        step(1);
        notes.push_back(st(7'h10));
        // Oscillator with one or two count units: stable between 58 and 122 cycles
        osc_ctrl_wr_i <= 1'b1;
        osc_enable_i <= 1'b1;
        osc_startup_count_i <= 8'h01 + 8'($urandom_range(1));
        step(1);
        osc_ctrl_wr_i <= 1'b0;
        step(40);
        notes.push_back(st(7'h10));
        step(120);
        notes.push_back(st(7'h11));
        step(200);
        notes.push_back(st(7'h13));
        $display("oscillator test done");
        // Pump bits first, then both loops with nonzero settings
        pump_current_wr_i <= 1'b1;
        pump_current_sel_i <= 2'h3;
        r = 19'($urandom);
        step(1);
        pump_current_wr_i <= 1'b0;
        loop_a_cfg_i <= '{1'b1, r[1:0], 11'(r[9:2]) | 11'h1, 2'h0, 6'h04, r[17:10] | 8'h1};
        loop_b_cfg_i <= '{1'b0, r[1:0], {3'h0, r[9:2]} | 11'h001, 2'h0, 6'h04, r[17:10] | 8'h01};
        loop_a_wr_i <= 1'b1;
        loop_b_wr_i <= 1'b1;
        step(1);
        loop_a_wr_i <= 1'b0;
        loop_b_wr_i <= 1'b0;
        notes.push_back(st(7'h13));
        notes.push_back({2'h3, loop_a_cfg_i.multiplier, loop_a_cfg_i.input_divider});
        step(20);
        notes.push_back(st(7'h13));
        // Main runs twice per slow period, so sixteen slow ticks hold 32 main edges
        notes.push_back({2'h2, 1'b0, 2'h3, 16'h0020});
        step(60);
        notes.push_back(st(7'h1f));
        // Rewrite loop A while moving the bus clock onto it
        loop_a_wr_i <= 1'b1;
        bus_clock_wr_i <= 1'b1;
        bus_clock_cfg_i <= '{2'h0, 3'h0, SRC_PLL_A};
        irq_enable_i <= clk_status_s'(r[6:0]);
        step(1);
        loop_a_wr_i <= 1'b0;
        bus_clock_wr_i <= 1'b0;
        notes.push_back(st(7'h0b));
        step(60);
        notes.push_back(st(7'h1f));
        $display("loop and bus clock test done");
        // Outputs reconfigured only while disabled
        output_clock_wr_i <= 2'h3;
        output_clock_cfg_i <= {r[4:0], r[9:5]};
        s = 19'h0;
        step(1);
        output_clock_wr_i <= 2'h0;
        // On and off masks together: off wins, zero bits leave state alone
        repeat (6) begin
            r = 19'($urandom);
            k = 19'($urandom);
            {output_clock_on_i, periph_clock_on_i} <= r;
            {output_clock_off_i, periph_clock_off_i} <= k;
            s = (s | r) & ~k;
            step(1);
            notes.push_back({2'h1, s});
        end
        {output_clock_on_i, periph_clock_on_i} <= 19'h0;
        {output_clock_off_i, periph_clock_off_i} <= 19'h0;
        step(3);
        $display("mask test done");
        print_verdict();
    end
endmodule : testbench
